// >>> eepc_defs.svh
`ifndef EEPC_DEFS_SVH
`define EEPC_DEFS_SVH
`define EEPC_ARRAY_FIRST 16'hb600
`define EEPC_ARRAY_LAST 16'hb7ff
`define EEPC_ARRAY_BYTES 512
`define EEPC_PROG_CTL_ADDR 16'h103b
`define EEPC_CONFIG_ADDR 16'h103f
`define EEPC_OPTION_ADDR 16'h1039
`define EEPC_PROG_RESET 8'h00
`define EEPC_PROG_MASK 8'hdf
`define EEPC_CONFIG_ERASED 8'h0f
`define EEPC_ERASED_BYTE 8'hff
`define EEPC_BIT_ODD 7
`define EEPC_BIT_EVEN 6
`define EEPC_BIT_BYTE 4
`define EEPC_BIT_ROW 3
`define EEPC_BIT_ERASE 2
`define EEPC_BIT_LATCH 1
`define EEPC_BIT_HV 0
`define EEPC_BIT_CHARGE_PUMP_CLOCK_SELECT 6
`define EEPC_BIT_MAP 0
`define EEPC_BIT_NOWD 2
`define EEPC_HV_DELAY_US 10000
`define EEPC_CLK_MHZ 40
`define EEPC_HV_DELAY_CYCLES (`EEPC_HV_DELAY_US * `EEPC_CLK_MHZ)
`define EEPC_REG_CMD 8'h00
`define EEPC_REG_ADDR 8'h04
`define EEPC_REG_DATA 8'h08
`define EEPC_REG_STATUS 8'h0c
`define EEPC_OP_PROGRAM 2'h0
`define EEPC_OP_ERASE 2'h1
`define EEPC_OP_READ 2'h2
`define EEPC_OP_WRITE 2'h3
`endif

// >>> eepc_pkg.sv
package eepc_pkg;
  typedef enum logic [9:0] {
    EEPC_IDLE = 10'h001,
    EEPC_CTL1 = 10'h002,
    EEPC_DATA = 10'h004,
    EEPC_CTL2 = 10'h008,
    EEPC_WAIT = 10'h010,
    EEPC_CTL3 = 10'h020,
    EEPC_CTL4 = 10'h040,
    EEPC_READ = 10'h080,
    EEPC_RWAIT = 10'h100,
    EEPC_RCAP = 10'h200
  } eepc_state_type;
endpackage : eepc_pkg

// >>> eepc_bus_if.sv
`timescale 1ns/1ps
interface eepc_bus_if;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport device (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : eepc_bus_if

// >>> eepc_delay.sv
`timescale 1ns/1ps
`include "eepc_defs.svh"
module eepc_delay #(
  parameter int unsigned CYCLES = `EEPC_HV_DELAY_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic start,
  output logic done
);
  logic [31:0] count;
  logic running;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count <= 32'h0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= 32'h1;
        running <= 1'b1;
      end else if (running) begin
        if (count >= CYCLES[31:0]) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count + 32'h1;
        end
      end
    end
  end
endmodule : eepc_delay

// >>> eepc_device.sv
`timescale 1ns/1ps
// Function
// - 512-byte array mapped at b600 to b7ff.
// - Map enable bit adds or removes array.
// - Reset loads map enable from stored cells.
// - Pump clock select chooses internal pump clock.
// - Host erase sequence with 10 ms high voltage.
// - Row erase picks row, bulk picks whole array.
// - Host program sequence with 10 ms high voltage.
// - Host clears high voltage, then whole control.
// - Byte and row bits decode erase size.
// - Erase bit selects erase or program.
// - Latch bit captures writes instead of reads.
// - High voltage bit applies array voltage.
// - Test bits program odd or even rows.
// - Config cells erase to 0f, visible after reset.
// - Config cells changeable only in special mode.
// - Watchdog reset disable bit suppresses timeout reset.
`include "eepc_defs.svh"
module eepc_device (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic por_n,
  input wire logic special_mode,
  input wire logic watchdog_timeout,
  eepc_bus_if.device bus,
  output logic array_map_enable,
  output logic watchdog_reset,
  output logic high_voltage_on,
  output logic charge_pump_clock_select,
  output logic [7:0] config_shadow
);
  logic [7:0] mem [0:`EEPC_ARRAY_BYTES-1];
  logic [7:0] prog_ctl;
  logic [7:0] nv_config;
  logic load_pending;
  logic [8:0] lat_addr;
  logic [7:0] lat_data;
  logic lat_armed;
  logic lat_config;
  logic hv_q;
  logic apply;
  logic [7:0] rdata;

  function automatic logic in_array(input logic [15:0] a);
    in_array = (a >= `EEPC_ARRAY_FIRST) && (a <= `EEPC_ARRAY_LAST);
  endfunction : in_array

  // Picks the bytes that one voltage pulse acts on.
  function automatic logic hit(input logic [8:0] i, input logic [8:0] la, input logic [7:0] pc);
    if (pc[`EEPC_BIT_ERASE]) begin
      if (pc[`EEPC_BIT_BYTE]) begin
        hit = (i == la);
      end else if (pc[`EEPC_BIT_ROW]) begin
        hit = (i[8:4] == la[8:4]);
      end else begin
        hit = 1'b1;
      end
    end else if (pc[`EEPC_BIT_ODD] || pc[`EEPC_BIT_EVEN]) begin
      hit = (i[8] == la[8]) && ((pc[`EEPC_BIT_ODD] && i[4]) ||
            (pc[`EEPC_BIT_EVEN] && !i[4]));
    end else begin
      hit = (i == la);
    end
  endfunction : hit

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prog_ctl <= `EEPC_PROG_RESET;
    end else if (bus.wr && bus.addr == `EEPC_PROG_CTL_ADDR) begin
      prog_ctl <= bus.wdata & `EEPC_PROG_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      charge_pump_clock_select <= 1'b0;
    end else if (bus.wr && bus.addr == `EEPC_OPTION_ADDR) begin
      charge_pump_clock_select <= bus.wdata[`EEPC_BIT_CHARGE_PUMP_CLOCK_SELECT];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      high_voltage_on <= 1'b0;
      hv_q <= 1'b0;
    end else begin
      high_voltage_on <= prog_ctl[`EEPC_BIT_HV];
      hv_q <= prog_ctl[`EEPC_BIT_HV];
    end
  end

  // The pulse acts once, at the rising edge of the voltage bit.
  assign apply = prog_ctl[`EEPC_BIT_HV] && !hv_q && prog_ctl[`EEPC_BIT_LATCH] &&
                 lat_armed;

  // ----------------------------------------------------------------
  // Address and data latches
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lat_addr <= 9'h000;
      lat_data <= 8'h00;
      lat_armed <= 1'b0;
      lat_config <= 1'b0;
    end else if (!prog_ctl[`EEPC_BIT_LATCH]) begin
      lat_armed <= 1'b0;
    end else if (bus.wr && array_map_enable && in_array(bus.addr)) begin
      lat_addr <= bus.addr[8:0];
      lat_data <= bus.wdata;
      lat_armed <= 1'b1;
      lat_config <= 1'b0;
    end else if (bus.wr && bus.addr == `EEPC_CONFIG_ADDR && special_mode) begin
      lat_data <= bus.wdata;
      lat_armed <= 1'b1;
      lat_config <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Array cells
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < `EEPC_ARRAY_BYTES; i++) begin
      if (apply && !lat_config && hit(9'(i), lat_addr, prog_ctl)) begin
        if (prog_ctl[`EEPC_BIT_ERASE]) begin
          mem[i] <= `EEPC_ERASED_BYTE;
        end else begin
          mem[i] <= mem[i] & lat_data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration cells
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge por_n) begin
    if (!por_n) begin
      nv_config <= `EEPC_CONFIG_ERASED;
    end else if (apply && lat_config && special_mode) begin
      if (prog_ctl[`EEPC_BIT_ERASE]) begin
        nv_config <= `EEPC_CONFIG_ERASED;
      end else begin
        nv_config <= nv_config & lat_data & `EEPC_CONFIG_ERASED;
      end
    end
  end

  // The readable copy follows the cells only once, just after reset.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      load_pending <= 1'b1;
      config_shadow <= `EEPC_CONFIG_ERASED;
    end else if (load_pending) begin
      load_pending <= 1'b0;
      config_shadow <= nv_config;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      array_map_enable <= 1'b0;
    end else begin
      array_map_enable <= config_shadow[`EEPC_BIT_MAP];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= watchdog_timeout && !config_shadow[`EEPC_BIT_NOWD];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      if (array_map_enable && in_array(bus.addr)) begin
        if (prog_ctl[`EEPC_BIT_LATCH]) begin
          rdata <= lat_data;
        end else begin
          rdata <= mem[bus.addr[8:0]];
        end
      end else if (bus.addr == `EEPC_PROG_CTL_ADDR) begin
        rdata <= prog_ctl;
      end else if (bus.addr == `EEPC_CONFIG_ADDR) begin
        rdata <= config_shadow & `EEPC_CONFIG_ERASED;
      end else if (bus.addr == `EEPC_OPTION_ADDR) begin
        rdata <= {1'b0, charge_pump_clock_select, 6'h00};
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  assign bus.rdata = rdata;
endmodule : eepc_device

// >>> eepc_host.sv
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "eepc_defs.svh"
module eepc_host #(
  parameter int unsigned HV_DELAY_CYCLES = `EEPC_HV_DELAY_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  eepc_bus_if.host bus,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  eepc_pkg::eepc_state_type state;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [15:0] tgt_addr;
  logic [7:0] tgt_data;
  logic [1:0] op;
  logic [1:0] size;
  logic [7:0] rd_byte;
  logic cmd_go;
  logic do_write;
  logic hv_start;
  logic hv_done;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] ctl_base;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

  eepc_delay #(.CYCLES(HV_DELAY_CYCLES)) u_delay (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(hv_start),
    .done(hv_done)
  );

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == `EEPC_REG_CMD || aw_addr == `EEPC_REG_ADDR ||
                        aw_addr == `EEPC_REG_DATA) ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tgt_addr <= 16'h0;
      tgt_data <= 8'h00;
    end else if (do_write && aw_addr == `EEPC_REG_ADDR) begin
      tgt_addr <= 16'(merge({16'h0, tgt_addr}, w_data, w_strb));
    end else if (do_write && aw_addr == `EEPC_REG_DATA && w_strb[0]) begin
      tgt_data <= w_data[7:0];
    end
  end

  // A command arriving while busy is dropped.
  assign cmd_go = do_write && aw_addr == `EEPC_REG_CMD && w_strb[0] &&
                  state == eepc_pkg::EEPC_IDLE;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `EEPC_REG_CMD: s_axi_rdata <= {28'h0, size, op};
        `EEPC_REG_ADDR: s_axi_rdata <= {16'h0, tgt_addr};
        `EEPC_REG_DATA: s_axi_rdata <= {24'h0, tgt_data};
        `EEPC_REG_STATUS: s_axi_rdata <= {16'h0, rd_byte, 7'h00,
                                          state != eepc_pkg::EEPC_IDLE};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign ctl_base = (op == `EEPC_OP_ERASE) ?
                    8'((1 << `EEPC_BIT_LATCH) | (1 << `EEPC_BIT_ERASE) |
                       (size[1] << `EEPC_BIT_BYTE) | (size[0] << `EEPC_BIT_ROW)) :
                    8'(1 << `EEPC_BIT_LATCH);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= eepc_pkg::EEPC_IDLE;
      op <= 2'h0;
      size <= 2'h0;
      rd_byte <= 8'h00;
    end else begin
      case (state)
        eepc_pkg::EEPC_IDLE: begin
          if (cmd_go) begin
            op <= w_data[1:0];
            size <= w_data[3:2];
            case (w_data[1:0])
              `EEPC_OP_WRITE: state <= eepc_pkg::EEPC_DATA;
              `EEPC_OP_READ: state <= eepc_pkg::EEPC_READ;
              default: state <= eepc_pkg::EEPC_CTL1;
            endcase
          end
        end
        eepc_pkg::EEPC_CTL1: state <= eepc_pkg::EEPC_DATA;
        eepc_pkg::EEPC_DATA: begin
          state <= (op == `EEPC_OP_WRITE) ? eepc_pkg::EEPC_IDLE : eepc_pkg::EEPC_CTL2;
        end
        eepc_pkg::EEPC_CTL2: state <= eepc_pkg::EEPC_WAIT;
        eepc_pkg::EEPC_WAIT: begin
          if (hv_done) begin
            state <= eepc_pkg::EEPC_CTL3;
          end
        end
        eepc_pkg::EEPC_CTL3: state <= eepc_pkg::EEPC_CTL4;
        eepc_pkg::EEPC_CTL4: state <= eepc_pkg::EEPC_IDLE;
        eepc_pkg::EEPC_READ: state <= eepc_pkg::EEPC_RWAIT;
        eepc_pkg::EEPC_RWAIT: state <= eepc_pkg::EEPC_RCAP;
        eepc_pkg::EEPC_RCAP: begin
          rd_byte <= bus.rdata;
          state <= eepc_pkg::EEPC_IDLE;
        end
        default: state <= eepc_pkg::EEPC_IDLE;
      endcase
    end
  end

  assign hv_start = (state == eepc_pkg::EEPC_CTL2);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bus_addr <= 16'h0;
      bus_wdata <= 8'h00;
      bus_wr <= 1'b0;
      bus_rd <= 1'b0;
    end else begin
      bus_wr <= 1'b0;
      bus_rd <= 1'b0;
      case (state)
        eepc_pkg::EEPC_CTL1, eepc_pkg::EEPC_CTL3: begin
          bus_wr <= 1'b1;
          bus_addr <= `EEPC_PROG_CTL_ADDR;
          bus_wdata <= ctl_base;
        end
        eepc_pkg::EEPC_DATA: begin
          bus_wr <= 1'b1;
          bus_addr <= tgt_addr;
          bus_wdata <= tgt_data;
        end
        eepc_pkg::EEPC_CTL2: begin
          bus_wr <= 1'b1;
          bus_addr <= `EEPC_PROG_CTL_ADDR;
          bus_wdata <= ctl_base | 8'(1 << `EEPC_BIT_HV);
        end
        eepc_pkg::EEPC_CTL4: begin
          bus_wr <= 1'b1;
          bus_addr <= `EEPC_PROG_CTL_ADDR;
          bus_wdata <= `EEPC_PROG_RESET;
        end
        eepc_pkg::EEPC_READ: begin
          bus_rd <= 1'b1;
          bus_addr <= tgt_addr;
        end
        default: begin
          bus_wr <= 1'b0;
        end
      endcase
    end
  end

  assign bus.addr = bus_addr;
  assign bus.wdata = bus_wdata;
  assign bus.wr = bus_wr;
  assign bus.rd = bus_rd;
endmodule : eepc_host

// >>> eepc_chk.sv
`timescale 1ns/1ps
module eepc_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic high_voltage_on,
  input wire logic array_map_enable,
  input wire logic charge_pump_clock_select,
  input wire logic watchdog_timeout,
  input wire logic watchdog_reset,
  input wire logic [7:0] config_shadow
);
  // ----------------------------------------------------------------
  // Mirrors of the control register and the latched array data.
  // ----------------------------------------------------------------
  logic [7:0] ctl_m;
  logic [7:0] lat_m;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctl_m <= 8'h00;
    end else if (wr && addr == 16'h103b) begin
      ctl_m <= wdata & 8'hdf;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lat_m <= 8'h00;
    end else if (wr && ctl_m[1] && addr[15:9] == 7'h5b) begin
      lat_m <= wdata;
    end
  end
  sequence ctl_wr_s;
    wr && addr == 16'h103b;
  endsequence
  sequence arr_rd_s;
    rd && addr[15:9] == 7'h5b;
  endsequence
  // ----------------------------------------------------------------
  // Properties.
  // ----------------------------------------------------------------
  hv_apply_a: assert property (ctl_wr_s |-> ##2 high_voltage_on == $past(wdata[0], 2))
    else $error("high voltage does not follow control bit");
  ctl_read_a: assert property (rd && addr == 16'h103b |=> rdata == $past(ctl_m))
    else $error("control register reads back wrong");
  map_follow_a: assert property ($changed(config_shadow[0]) |=> array_map_enable == $past(config_shadow[0]))
    else $error("map enable does not follow config copy");
  map_absent_a: assert property (arr_rd_s and !array_map_enable && !ctl_m[1] |=> rdata == 8'h00)
    else $error("array visible while disabled");
  unmap_rd_a: assert property (rd && addr < 16'h1000 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  latch_rd_a: assert property (arr_rd_s and ctl_m[1] |=> rdata == $past(lat_m))
    else $error("latched read not latched data");
  pump_sel_a: assert property (wr && addr == 16'h1039 |=> charge_pump_clock_select == $past(wdata[6]))
    else $error("pump clock select not taken");
  wd_fire_a: assert property (watchdog_timeout && !config_shadow[2] |=> watchdog_reset)
    else $error("watchdog reset missing");
  wd_quiet_a: assert property (watchdog_reset |-> $past(watchdog_timeout) && !$past(config_shadow[2]))
    else $error("watchdog reset without cause");
endmodule : eepc_chk

// >>> eeprom_program_erase_control_tb_top.sv
`timescale 1ns/1ps
module eeprom_program_erase_control_tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic por_n = 1'b0;
  logic special_mode = 1'b0;
  logic wd_to = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, map_en, wd_rst, hv, cpcs;
  logic [1:0] bresp, rresp;
  logic [31:0] rdat, s;
  logic [7:0] cfg;
  int miscompares = 0;
  int checked = 0;
  eepc_bus_if bus_if ();
  eepc_host #(.HV_DELAY_CYCLES(8)) i_eepc_host (.clk_sys(clk_sys), .rstn(rstn), .bus(bus_if),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdat), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  eepc_device i_eepc_device (.clk_sys(clk_sys), .rstn(rstn), .por_n(por_n),
    .special_mode(special_mode), .watchdog_timeout(wd_to), .bus(bus_if),
    .array_map_enable(map_en), .watchdog_reset(wd_rst), .high_voltage_on(hv),
    .charge_pump_clock_select(cpcs), .config_shadow(cfg));
  eepc_chk i_chk (.clk_sys(clk_sys), .rstn(rstn), .addr(bus_if.addr), .wdata(bus_if.wdata),
    .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata), .high_voltage_on(hv),
    .array_map_enable(map_en), .charge_pump_clock_select(cpcs), .watchdog_timeout(wd_to),
    .watchdog_reset(wd_rst), .config_shadow(cfg));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------
  // Bus and check tasks.
  // ----------------------------------------------------------------
  task report_and_stop;
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task stall;
    miscompares++;
    $display("MISMATCH %0t wait timed out", $time);
    report_and_stop();
  endtask : stall
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    awaddr <= a; wdat <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100) stall();
    bready <= 1'b0;
    chk({30'h0, bresp}, 32'h0, "write response");
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, input logic [1:0] er);
    int n;
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    if (n >= 100) stall();
    s = rdat;
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er}, "read response");
  endtask : axi_rd
  task hop(input logic [3:0] cmd, input logic [15:0] a, input logic [7:0] d);
    int n;
    axi_wr(8'h04, {16'h0, a});
    axi_wr(8'h08, {24'h0, d});
    axi_wr(8'h00, {28'h0, cmd});
    n = 0;
    s = 32'h1;
    while (s[0] !== 1'b0 && n < 60) begin
      axi_rd(8'h0c, 2'b00);
      n++;
    end
    if (n >= 60) stall();
  endtask : hop
  task hrd(input logic [15:0] a, input logic [7:0] e);
    hop(4'h2, a, 8'h00);
    axi_rd(8'h0c, 2'b00);
    chk({24'h0, s[15:8]}, {24'h0, e}, "device read");
  endtask : hrd
  task rst_pulse;
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : rst_pulse
  task wdt(input logic e);
    @(posedge clk_sys);
    wd_to <= 1'b1;
    @(posedge clk_sys);
    wd_to <= 1'b0;
    #1;
    chk({31'h0, wd_rst}, {31'h0, e}, "watchdog reset");
  endtask : wdt
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    por_n <= 1'b1;
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({24'h0, cfg}, 32'h0f, "config after power up");
    chk({31'h0, map_en}, 32'h1, "map enable");
    hrd(16'h103b, 8'h00);
    axi_rd(8'h10, 2'b10);
    chk(s, 32'h0, "unmapped register");
    hrd(16'h0100, 8'h00);
    hop(4'h1, 16'hb6a3, 8'h00);
    hrd(16'hb600, 8'hff);
    hrd(16'hb7ff, 8'hff);
    hop(4'h0, 16'hb600, 8'h5a);
    hrd(16'hb600, 8'h5a);
    hop(4'h0, 16'hb600, 8'hf0);
    hrd(16'hb600, 8'h50);
    chk({31'h0, hv}, 32'h0, "voltage off");
    hrd(16'h103b, 8'h00);
    hop(4'h0, 16'hb61f, 8'h00);
    hop(4'h0, 16'hb620, 8'h00);
    hop(4'h0, 16'hb621, 8'h00);
    hop(4'h5, 16'hb615, 8'h00);
    hrd(16'hb61f, 8'hff);
    hrd(16'hb620, 8'h00);
    hrd(16'hb600, 8'h50);
    hop(4'hd, 16'hb620, 8'h00);
    hrd(16'hb620, 8'hff);
    hrd(16'hb621, 8'h00);
    hop(4'h3, 16'hb640, 8'h00);
    hrd(16'hb640, 8'hff);
    hop(4'h3, 16'h103b, 8'h02);
    hop(4'h3, 16'hb640, 8'h33);
    hrd(16'hb640, 8'h33);
    hop(4'h3, 16'h103b, 8'h00);
    hrd(16'hb640, 8'hff);
    hop(4'h3, 16'h103b, 8'h82);
    hop(4'h3, 16'hb650, 8'h3c);
    hop(4'h3, 16'h103b, 8'h83);
    hop(4'h3, 16'h103b, 8'h00);
    hrd(16'hb630, 8'h3c);
    hrd(16'hb640, 8'hff);
    hrd(16'hb7f0, 8'hff);
    hop(4'h3, 16'h1039, 8'h40);
    chk({31'h0, cpcs}, 32'h1, "pump clock select");
    hrd(16'h1039, 8'h40);
    hop(4'h3, 16'h1039, 8'h00);
    chk({31'h0, cpcs}, 32'h0, "pump clock select");
    wdt(1'b0);
    hop(4'h0, 16'h103f, 8'h0b);
    rst_pulse();
    chk({24'h0, cfg}, 32'h0f, "config outside special mode");
    special_mode <= 1'b1;
    hop(4'h0, 16'h103f, 8'h0b);
    chk({24'h0, cfg}, 32'h0f, "config before reset");
    rst_pulse();
    chk({24'h0, cfg}, 32'h0b, "config after reset");
    wdt(1'b1);
    hop(4'h0, 16'h103f, 8'h0a);
    rst_pulse();
    chk({31'h0, map_en}, 32'h0, "map disabled");
    hrd(16'hb600, 8'h00);
    report_and_stop();
  end
endmodule : eeprom_program_erase_control_tb_top
